// ==== design/tcpo_map.svh ====
// register offsets, field positions, reset values of the capture/compare timer
`ifndef TCPO_MAP_SVH
`define TCPO_MAP_SVH

// ==========================================================================
// register byte offsets (apb, one aligned word each)
// ==========================================================================
`define TCPO_MODE_OFS 8'h00
`define TCPO_CCCTL_OFS 8'h04
`define TCPO_OUTCTL_OFS 8'h08
`define TCPO_EDGE_OFS 8'h0c
`define TCPO_COUNT_OFS 8'h10
`define TCPO_CC1_OFS 8'h14
`define TCPO_CC2_OFS 8'h18

// ==========================================================================
// mode_control_reg fields
// ==========================================================================
`define TCPO_OVF_BIT 0
`define TCPO_TOGGLE_BIT 1
`define TCPO_MODE_LO 2
`define TCPO_MODE_HI 3

// ==========================================================================
// capture/compare control fields
// ==========================================================================
`define TCPO_CC1_CAP_BIT 0
`define TCPO_CC1_SRC_BIT 1
`define TCPO_CC2_CAP_BIT 2

// ==========================================================================
// output_control_reg fields
// ==========================================================================
`define TCPO_OS_EN_BIT 5
`define TCPO_OS_TRIG_BIT 6

// ==========================================================================
// edge select fields (bit0 falling, bit1 rising)
// ==========================================================================
`define TCPO_PRI_EDGE_LO 0
`define TCPO_PRI_EDGE_HI 1
`define TCPO_SEC_EDGE_LO 2
`define TCPO_SEC_EDGE_HI 3

// ==========================================================================
// reset values
// ==========================================================================
`define TCPO_CFG_RST 11'h000
`define TCPO_CNT_RST 16'h0000
`define TCPO_CC_RST 16'h0000
`define TCPO_RDATA_RST 32'h0000_0000

`endif

// ==== design/tcpo_pkg.sv ====
// types shared by the capture/compare timer design
package tcpo_pkg;

    // ======================================================================
    // counter operating modes, in mode-field order 00..11
    // ======================================================================
    typedef enum logic [1:0] {
        TCPO_STOP,
        TCPO_FREE,
        TCPO_EDGE_CLEAR,
        TCPO_PULSE_GEN
    } tcpo_mode_e;

    // ======================================================================
    // software configuration carried as one bundle
    // ======================================================================
    typedef struct packed {
        logic edge_toggle;     // toggle output on primary edge
        tcpo_mode_e mode;      // counter mode field
        logic cc1_cap;         // first register captures
        logic cc1_src_pri;     // first register triggered by primary pin
        logic cc2_cap;         // second register captures
        logic os_en;           // one-shot enable
        logic [1:0] pri_edge;  // primary pin edge select
        logic [1:0] sec_edge;  // secondary pin edge select
    } tcpo_cfg_s;

endpackage : tcpo_pkg

// ==== design/tcpo_edge.sv ====
// valid-edge detector for the two trigger pins
`timescale 1ns/1ns
module tcpo_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic edge_pulse
);

    // ======================================================================
    // previous level and arm flag
    // ======================================================================
    logic prev_reg; // level seen last cycle
    logic armed_reg; // blocks a false edge on the first cycle after reset

    // history of the pin, pin is already synchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            prev_reg <= pin;
            armed_reg <= 1'b1;
        end
    end

    // bit1 selects rising, bit0 falling, both for 2'b11
    assign edge_pulse = armed_reg & ((sel[1] & pin & ~prev_reg) | (sel[0] & ~pin & prev_reg));

endmodule : tcpo_edge

// ==== design/tcpo_top.sv ====
// 16-bit capture/compare timer with pulse generation and one-shot output, apb slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "tcpo_map.svh"

// Functional notes
// - dual capture free-run leaves output unchanged
// - toggle bit set: primary edge toggles output
// - primary edge to second, secondary to first
// - secondary-only edges never load second register
// - first compare match irq, counter not cleared
// - second compare match irq, counter keeps running
// - first capture triggered by selected pin edge
// - second capture always triggered by primary pin
// - mode 11 clears on first match, pulse train
// - period first+1, width second+1 clocks
// - first match clears, second match does not
// - one-shot only in modes 01/10 with enable
// - trigger clears counter, one pulse of difference
// - counter readable at any time
// - wrap from ffff in modes 01/10 sets overflow flag
// - one-shot matches raise irq and toggle output
module tcpo_top import tcpo_pkg::*; #(
    parameter int CW = 16,
    parameter int AW = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PRIMARY_TRIGGER_PIN,
    input wire logic SECONDARY_TRIGGER_PIN,
    output logic TIMER_OUT_PIN,
    output logic FIRST_MATCH_IRQ,
    output logic SECOND_MATCH_IRQ
);

    // ======================================================================
    // state and decoded strobes
    // ======================================================================
    tcpo_cfg_s cfg_reg; // software configuration
    logic overflow_flag_reg; // sticky wrap flag
    logic [CW-1:0] up_counter_reg; // the count
    logic [CW-1:0] first_cc_reg; // compare period or capture
    logic [CW-1:0] second_cc_reg; // compare width or capture
    logic out_reg; // timer output level
    logic irq1_reg; // first event pulse
    logic irq2_reg; // second event pulse
    logic [31:0] prdata_reg; // read data latched in setup
    logic [31:0] rd_next; // read mux
    logic [1:0] pin_vec; // trigger pins as a vector
    logic [1:0] edge_sel [2]; // edge selects per pin
    logic [1:0] edge_vec; // valid edge pulses
    logic pe; // primary valid edge
    logic se; // secondary valid edge
    logic access; // apb access phase
    logic wr; // write taken this edge
    logic sw_trig; // software one-shot trigger
    logic running; // not stopped
    logic os_act; // one-shot armed
    logic cap1_mode; // first register captures
    logic cap2_mode; // second register captures
    logic cap1_ev; // first capture event
    logic cap2_ev; // second capture event
    logic m1; // first compare match
    logic m2; // second compare match
    logic clr; // counter clear
    logic ovf_set; // wrap event
    logic all_ones; // counter at top

    // decode of mapped word addresses, used by bus answer and write enable
    function automatic logic tcpo_hit(input logic [AW-1:0] a);
        tcpo_hit = (a == `TCPO_MODE_OFS) || (a == `TCPO_CCCTL_OFS) ||
                   (a == `TCPO_OUTCTL_OFS) || (a == `TCPO_EDGE_OFS) ||
                   (a == `TCPO_COUNT_OFS) || (a == `TCPO_CC1_OFS) ||
                   (a == `TCPO_CC2_OFS);
    endfunction : tcpo_hit

    // ======================================================================
    // apb slave: zero wait states, error on unmapped words
    // ======================================================================
    assign access = PSEL & PENABLE;
    assign PREADY = access;
    assign PSLVERR = access & ~tcpo_hit(PADDR);
    assign wr = access & PWRITE & tcpo_hit(PADDR);
    // software trigger bit is write-only and self clearing
    assign sw_trig = wr & (PADDR == `TCPO_OUTCTL_OFS) & PWDATA[`TCPO_OS_TRIG_BIT];
    assign PRDATA = prdata_reg;

    // read mux, unused bits read as zero
    always_comb begin
        rd_next = '0;
        case (PADDR)
            `TCPO_MODE_OFS: begin
                rd_next[`TCPO_OVF_BIT] = overflow_flag_reg;
                rd_next[`TCPO_TOGGLE_BIT] = cfg_reg.edge_toggle;
                rd_next[`TCPO_MODE_HI:`TCPO_MODE_LO] = cfg_reg.mode;
            end
            `TCPO_CCCTL_OFS: begin
                rd_next[`TCPO_CC1_CAP_BIT] = cfg_reg.cc1_cap;
                rd_next[`TCPO_CC1_SRC_BIT] = cfg_reg.cc1_src_pri;
                rd_next[`TCPO_CC2_CAP_BIT] = cfg_reg.cc2_cap;
            end
            `TCPO_OUTCTL_OFS: rd_next[`TCPO_OS_EN_BIT] = cfg_reg.os_en;
            `TCPO_EDGE_OFS: begin
                rd_next[`TCPO_PRI_EDGE_HI:`TCPO_PRI_EDGE_LO] = cfg_reg.pri_edge;
                rd_next[`TCPO_SEC_EDGE_HI:`TCPO_SEC_EDGE_LO] = cfg_reg.sec_edge;
            end
            `TCPO_COUNT_OFS: rd_next[CW-1:0] = up_counter_reg;
            `TCPO_CC1_OFS: rd_next[CW-1:0] = first_cc_reg;
            `TCPO_CC2_OFS: rd_next[CW-1:0] = second_cc_reg;
            default: rd_next = '0;
        endcase
    end

    // read data caught in setup so the output comes from a flop;
    // the count is therefore the value of the setup cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_reg <= `TCPO_RDATA_RST;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            prdata_reg <= rd_next;
        end
    end

    // configuration writes
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_reg <= tcpo_cfg_s'(`TCPO_CFG_RST);
        end else if (wr) begin
            case (PADDR)
                `TCPO_MODE_OFS: begin
                    cfg_reg.edge_toggle <= PWDATA[`TCPO_TOGGLE_BIT];
                    cfg_reg.mode <= tcpo_mode_e'(PWDATA[`TCPO_MODE_HI:`TCPO_MODE_LO]);
                end
                `TCPO_CCCTL_OFS: begin
                    cfg_reg.cc1_cap <= PWDATA[`TCPO_CC1_CAP_BIT];
                    cfg_reg.cc1_src_pri <= PWDATA[`TCPO_CC1_SRC_BIT];
                    cfg_reg.cc2_cap <= PWDATA[`TCPO_CC2_CAP_BIT];
                end
                `TCPO_OUTCTL_OFS: cfg_reg.os_en <= PWDATA[`TCPO_OS_EN_BIT];
                `TCPO_EDGE_OFS: begin
                    cfg_reg.pri_edge <= PWDATA[`TCPO_PRI_EDGE_HI:`TCPO_PRI_EDGE_LO];
                    cfg_reg.sec_edge <= PWDATA[`TCPO_SEC_EDGE_HI:`TCPO_SEC_EDGE_LO];
                end
                default: cfg_reg <= cfg_reg; // read-only or register words
            endcase
        end
    end

    // ======================================================================
    // trigger pin edge detection, one detector per pin
    // ======================================================================
    assign pin_vec = {SECONDARY_TRIGGER_PIN, PRIMARY_TRIGGER_PIN};
    assign edge_sel[0] = cfg_reg.pri_edge;
    assign edge_sel[1] = cfg_reg.sec_edge;

    for (genvar g = 0; g < 2; g++) begin : g_edge
        tcpo_edge u_edge (
            .clk(CORE_CLK),
            .rst_n(RST_N),
            .pin(pin_vec[g]),
            .sel(edge_sel[g]),
            .edge_pulse(edge_vec[g])
        );
    end

    assign pe = edge_vec[0];
    assign se = edge_vec[1];

    // ======================================================================
    // event decode
    // ======================================================================
    assign running = cfg_reg.mode != TCPO_STOP;
    assign os_act = cfg_reg.os_en &
                    ((cfg_reg.mode == TCPO_FREE) | (cfg_reg.mode == TCPO_EDGE_CLEAR));
    // one-shot and pulse generation force both registers to compare
    assign cap1_mode = cfg_reg.cc1_cap & ~os_act & (cfg_reg.mode != TCPO_PULSE_GEN);
    assign cap2_mode = cfg_reg.cc2_cap & ~os_act & (cfg_reg.mode != TCPO_PULSE_GEN);
    assign cap1_ev = running & cap1_mode & (cfg_reg.cc1_src_pri ? pe : se);
    assign cap2_ev = running & cap2_mode & pe;
    assign m1 = running & ~cap1_mode & (up_counter_reg == first_cc_reg);
    assign m2 = running & ~cap2_mode & (up_counter_reg == second_cc_reg);
    // only the one-shot trigger, mode 10 edge and mode 11 match restart the count
    assign clr = ((cfg_reg.mode == TCPO_PULSE_GEN) & m1) |
                 (os_act & (sw_trig | pe)) |
                 ((cfg_reg.mode == TCPO_EDGE_CLEAR) & pe);
    assign all_ones = &up_counter_reg;
    assign ovf_set = ((cfg_reg.mode == TCPO_FREE) | (cfg_reg.mode == TCPO_EDGE_CLEAR)) &
                     all_ones & ~clr;

    // ======================================================================
    // counter and overflow
    // ======================================================================
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            up_counter_reg <= `TCPO_CNT_RST;
        end else if (!running) begin
            up_counter_reg <= '0;
        end else if (clr) begin
            up_counter_reg <= '0;
        end else begin
            up_counter_reg <= up_counter_reg + CW'(1); // wraps to zero
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag_reg <= 1'b1;
        end else if (wr && PADDR == `TCPO_MODE_OFS && !PWDATA[`TCPO_OVF_BIT]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // ======================================================================
    // capture/compare registers: capture beats a software write
    // ======================================================================
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_cc_reg <= `TCPO_CC_RST;
        end else if (cap1_ev) begin
            first_cc_reg <= up_counter_reg;
        end else if (wr && PADDR == `TCPO_CC1_OFS) begin
            first_cc_reg <= PWDATA[CW-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            second_cc_reg <= `TCPO_CC_RST;
        end else if (cap2_ev) begin
            second_cc_reg <= up_counter_reg;
        end else if (wr && PADDR == `TCPO_CC2_OFS) begin
            second_cc_reg <= PWDATA[CW-1:0];
        end
    end

    // ======================================================================
    // timer output and event pulses
    // ======================================================================
    // pulse generation sets on period match, drops after width match;
    // other running modes toggle, stop holds the level
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_reg <= 1'b0;
        end else if (cfg_reg.mode == TCPO_PULSE_GEN) begin
            if (m1) begin
                out_reg <= 1'b1;
            end else if (m2) begin
                out_reg <= 1'b0;
            end
        end else if (running) begin
            // toggles on each match, and on a primary edge when the toggle bit is set outside one-shot
            out_reg <= out_reg ^ m1 ^ m2 ^ (cfg_reg.edge_toggle & pe & ~os_act);
        end
    end

    // one-cycle event pulses, a cycle after the cause
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq1_reg <= 1'b0;
            irq2_reg <= 1'b0;
        end else begin
            irq1_reg <= m1 | cap1_ev;
            irq2_reg <= m2 | cap2_ev;
        end
    end

    assign TIMER_OUT_PIN = out_reg;
    assign FIRST_MATCH_IRQ = irq1_reg;
    assign SECOND_MATCH_IRQ = irq2_reg;

    // ======================================================================
    // assertions and covers
    // ======================================================================
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    stop_hold_a: assert property (!running |=> up_counter_reg == '0 && !FIRST_MATCH_IRQ)
        else $error("stopped counter not held at zero");
    count_inc_a: assert property ((running && !clr) |=>
        up_counter_reg == $past(up_counter_reg) + CW'(1))
        else $error("counter did not advance by one");
    ovf_wrap_a: assert property (ovf_set |=> overflow_flag_reg && up_counter_reg == '0)
        else $error("wrap did not set overflow");
    pulse_clear_a: assert property ((cfg_reg.mode == TCPO_PULSE_GEN && m1) |=>
        up_counter_reg == '0 && TIMER_OUT_PIN && FIRST_MATCH_IRQ)
        else $error("period match did not restart");
    pulse_low_a: assert property ((cfg_reg.mode == TCPO_PULSE_GEN && m2 && !m1) |=>
        !TIMER_OUT_PIN && SECOND_MATCH_IRQ)
        else $error("width match did not drop output");
    cmp_noclr_a: assert property ((cfg_reg.mode == TCPO_FREE && m2 && !clr) |=>
        up_counter_reg != '0 || $past(all_ones))
        else $error("second match cleared the counter");
    cap_second_a: assert property (cap2_ev |=>
        second_cc_reg == $past(up_counter_reg) && SECOND_MATCH_IRQ)
        else $error("second register missed capture");
    cap_first_a: assert property (cap1_ev |=>
        first_cc_reg == $past(up_counter_reg) && FIRST_MATCH_IRQ)
        else $error("first register missed capture");
    no_load_a: assert property ((cap2_mode && !pe && !wr) |=> $stable(second_cc_reg))
        else $error("second register loaded without primary edge");
    out_hold_a: assert property ((cap1_mode && cap2_mode && !cfg_reg.edge_toggle &&
        cfg_reg.mode != TCPO_PULSE_GEN) |=> $stable(TIMER_OUT_PIN))
        else $error("output moved in dual capture");
    edge_tog_a: assert property ((cfg_reg.mode == TCPO_FREE && cap1_mode && cap2_mode &&
        cfg_reg.edge_toggle && pe) |=> TIMER_OUT_PIN != $past(TIMER_OUT_PIN))
        else $error("primary edge did not toggle output");
    os_start_a: assert property ((os_act && sw_trig) |=> up_counter_reg == '0)
        else $error("one-shot trigger did not restart");
    os_gate_a: assert property ((cfg_reg.mode == TCPO_PULSE_GEN && sw_trig && !m1) |=>
        up_counter_reg != '0)
        else $error("trigger acted outside one-shot modes");
    os_tog_a: assert property ((os_act && (m1 ^ m2)) |=>
        TIMER_OUT_PIN != $past(TIMER_OUT_PIN))
        else $error("one-shot match did not toggle");
    cnt_read_a: assert property ((PSEL && !PENABLE && !PWRITE &&
        PADDR == `TCPO_COUNT_OFS) |=> PRDATA[CW-1:0] == $past(up_counter_reg))
        else $error("count read wrong");

    pulse_cycle_c: cover property (cfg_reg.mode == TCPO_PULSE_GEN && m1);
    os_trig_c: cover property (os_act && sw_trig ##[1:300] os_act && m2);
    dual_cap_c: cover property (cap1_ev ##[1:100] cap2_ev);
    wrap_c: cover property (ovf_set);

endmodule : tcpo_top

// ==== testbench/tcpo_pins.sv ====
// partner model of the trigger pins and timer output
`timescale 1ns/1ns
// ==========================================
// trigger pin driver
// ==========================================
module tcpo_pins (
    input wire logic clk,
    output logic pri_pin,
    output logic sec_pin,
    input wire logic tout
);
    int tout_moves = 0; // output level changes seen at the far side
    logic tout_last = 1'b0; // output level one cycle ago
    // pins rest low; they only move on request, so no stray edges
    initial begin
        pri_pin = 1'b0;
        sec_pin = 1'b0;
    end
    // far side watches the output pin and counts its level changes
    always @(posedge clk) begin
        tout_last <= tout;
        if (tout !== tout_last) tout_moves <= tout_moves + 1;
    end
    // level change right after an edge, held until the next request
    task set_pri(input logic v);
        @(posedge clk);
        pri_pin <= v;
    endtask : set_pri
    // secondary pin, same timing as the primary
    task set_sec(input logic v);
        @(posedge clk);
        sec_pin <= v;
    endtask : set_sec
endmodule : tcpo_pins

// ==== testbench/testbench.sv ====
// self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`include "tcpo_map.svh"
module testbench import tcpo_pkg::*;;
    // ==========================================
    // signals
    // ==========================================
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdv, a, b;
    logic pready, pslverr, erv, pri, sec, tout, irq1, irq2, lv;
    int miscompares = 0, samples_checked = 0, cycles = 0, n;
    int n1 = 0, n2 = 0, s1, s2, mv;
    // 25 MHz clock
    always #20 clk = ~clk;
    tcpo_top tcpo_top_i (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PRIMARY_TRIGGER_PIN(pri), .SECONDARY_TRIGGER_PIN(sec),
        .TIMER_OUT_PIN(tout), .FIRST_MATCH_IRQ(irq1), .SECOND_MATCH_IRQ(irq2));
    tcpo_pins tcpo_pins_i (.clk(clk), .pri_pin(pri), .sec_pin(sec), .tout(tout));
    // ==========================================
    // helpers
    // ==========================================
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // event pulse counters; a pulse stands one cycle, so count every edge
    always @(posedge clk) begin
        if (irq1 === 1'b1) n1 <= n1 + 1;
        if (irq2 === 1'b1) n2 <= n2 + 1;
    end
    // hang guard, the tests need about 66000 cycles (one full wrap included)
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            miscompares++;
            complete_run();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // apb transfer: setup, then access held until pready
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: only the hang guard ends a stuck transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // skip a partial phase, then count cycles the output stays at lvl
    task lvl_width(input logic lvl, output int w);
        w = 0;
        while (tout === lvl) begin
            @(posedge clk);
        end
        while (tout !== lvl) begin
            @(posedge clk);
        end
        while (tout === lvl) begin
            @(posedge clk);
            w++;
        end
    endtask : lvl_width
    // ==========================================
    // tests
    // ==========================================
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped address
        apb(1'b0, `TCPO_MODE_OFS, 0);
        chk(rdv, 0);
        apb(1'b0, 8'h1c, 0);
        chk(rdv, 0);
        chk(erv, 1);
        // stopped: counter held at zero
        repeat (5) @(posedge clk);
        apb(1'b0, `TCPO_COUNT_OFS, 0);
        chk(rdv, 0);
        // dual capture, both edges on both pins, free running
        apb(1'b1, `TCPO_CCCTL_OFS, 32'h05);
        apb(1'b1, `TCPO_EDGE_OFS, 32'h0f);
        apb(1'b1, `TCPO_MODE_OFS, 32'h04);
        s1 = n1;
        s2 = n2;
        lv = tout;
        tcpo_pins_i.set_pri(1'b1);
        repeat (9) @(posedge clk);
        tcpo_pins_i.set_sec(1'b1);
        repeat (5) @(posedge clk);
        apb(1'b0, `TCPO_CC2_OFS, 0);
        a = rdv;
        apb(1'b0, `TCPO_CC1_OFS, 0);
        chk(rdv[15:0] - a[15:0], 32'd10);
        chk(tout, lv);
        chk(n1 - s1, 1);
        chk(n2 - s2, 1);
        // counter read twice, setups three cycles apart
        apb(1'b0, `TCPO_COUNT_OFS, 0);
        b = rdv;
        apb(1'b0, `TCPO_COUNT_OFS, 0);
        chk(rdv[15:0] - b[15:0], 32'd3);
        // only secondary edges: second register keeps its value
        apb(1'b1, `TCPO_EDGE_OFS, 32'h0c);
        tcpo_pins_i.set_pri(1'b0);
        tcpo_pins_i.set_sec(1'b0);
        repeat (4) @(posedge clk);
        apb(1'b0, `TCPO_CC2_OFS, 0);
        chk(rdv, a);
        // toggle bit: primary edge inverts the output
        apb(1'b1, `TCPO_EDGE_OFS, 32'h03);
        apb(1'b1, `TCPO_MODE_OFS, 32'h06);
        lv = tout;
        tcpo_pins_i.set_pri(1'b1);
        repeat (4) @(posedge clk);
        chk(tout, !lv);
        // mode 10, first register on the primary pin: a falling edge clears
        // the count and both registers catch the same pre-clear value
        apb(1'b1, `TCPO_CCCTL_OFS, 32'h07);
        apb(1'b1, `TCPO_MODE_OFS, 32'h08);
        tcpo_pins_i.set_pri(1'b0);
        apb(1'b0, `TCPO_COUNT_OFS, 0);
        chk(rdv, 0);
        apb(1'b0, `TCPO_CC2_OFS, 0);
        a = rdv;
        apb(1'b0, `TCPO_CC1_OFS, 0);
        chk(rdv, a);
        // pulse generation: period first+1, high second+1
        apb(1'b1, `TCPO_MODE_OFS, 32'h00);
        apb(1'b1, `TCPO_CCCTL_OFS, 32'h00);
        apb(1'b1, `TCPO_CC1_OFS, 32'h07);
        apb(1'b1, `TCPO_CC2_OFS, 32'h02);
        apb(1'b1, `TCPO_MODE_OFS, 32'h0c);
        // enable plus trigger outside modes 01/10 must not restart the count
        apb(1'b1, `TCPO_OUTCTL_OFS, 32'h60);
        lvl_width(1'b1, n);
        chk(n, 3);
        lvl_width(1'b0, n);
        chk(n, 5);
        // one shot: software trigger, pulse of the register difference
        apb(1'b1, `TCPO_MODE_OFS, 32'h00);
        apb(1'b1, `TCPO_CC1_OFS, 32'h100);
        apb(1'b1, `TCPO_CC2_OFS, 32'h104);
        apb(1'b1, `TCPO_OUTCTL_OFS, 32'h20);
        apb(1'b1, `TCPO_MODE_OFS, 32'h04);
        s1 = n1;
        s2 = n2;
        mv = tcpo_pins_i.tout_moves;
        apb(1'b1, `TCPO_OUTCTL_OFS, 32'h60);
        lv = tout;
        lvl_width(~lv, n);
        chk(n, 4);
        repeat (2) @(posedge clk);
        chk(n1 - s1, 1);
        chk(n2 - s2, 1);
        chk(tcpo_pins_i.tout_moves - mv, 2);
        // one full lap of the counter: the wrap sets the overflow flag,
        // and a zero written to it clears it again
        repeat (65536) @(posedge clk);
        apb(1'b0, `TCPO_MODE_OFS, 0);
        chk(rdv, 32'h05);
        apb(1'b1, `TCPO_MODE_OFS, 32'h04);
        apb(1'b0, `TCPO_MODE_OFS, 0);
        chk(rdv, 32'h04);
        complete_run();
    end
endmodule : testbench
